/* File: inc/sstx_pkg.sv */
// Constants and operation codes for the swap, skip, table and xor unit
package sstx_pkg;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned PROG_W     = 16;
    localparam int unsigned PADDR_W    = 12;
    localparam int unsigned BIT_SEL_W  = 3;
    localparam int unsigned NIB_LO_MSB = 3;
    localparam int unsigned NIB_HI_LSB = 4;
    localparam logic [7:0]  ACC_RST    = 8'h00;
    localparam logic [7:0]  TABLE_HIGH_BYTE_LATCH_RST   = 8'h00;
    localparam logic        ZF_RST     = 1'b0;
    localparam int unsigned OP_W       = 4;

    typedef enum logic [3:0] {
        SSTX_OP_NONE,
        SSTX_OP_SWAP_MEM,
        SSTX_OP_SWAP_ACC,
        SSTX_OP_SKIP_ZERO,
        SSTX_OP_COPY_SKIP,
        SSTX_OP_SKIP_BIT,
        SSTX_OP_TAB_GIVEN,
        SSTX_OP_TAB_CURR,
        SSTX_OP_TAB_LAST,
        SSTX_OP_XOR_ACC,
        SSTX_OP_XOR_MEM,
        SSTX_OP_XOR_IMM
    } sstx_op_e;
endpackage : sstx_pkg

/* File: src/sstx_prog_rom.sv */
// Small program memory with registered read data for table reads
`timescale 1ns/1ps
`default_nettype none
module sstx_prog_rom #(
    parameter int unsigned AW = 12,
    parameter int unsigned DW = 16
) (
    // Clock
    input  wire logic          ref_clk_i,
    // Write port for loading code
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [DW-1:0] wr_data_i,
    // Read port
    input  wire logic          rd_en_i,
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [DW-1:0] rd_data_o
);
    logic [DW-1:0] mem_q [0:(1<<AW)-1];

    // Contents are undefined until loaded; no reset on the array
    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
        if (rd_en_i) begin
            rd_data_o <= mem_q[rd_addr_i];
        end
    end
endmodule : sstx_prog_rom
`default_nettype wire

/* File: src/sstx_exec.sv */
// Execution unit for nibble swap, zero skips, table reads and xor
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Swap into memory writes the byte back with nibbles exchanged, no flags.
// - Swap to accumulator loads exchanged byte, memory and flags untouched.
// - Met skip condition inserts a dummy cycle; skip takes two cycles.
// - Unmet skip condition proceeds with the next instruction normally.
// - Byte zero test skips when the addressed byte is zero.
// - Copy and test loads accumulator and skips if value is zero.
// - Bit zero test skips when the selected bit is zero.
// - Given-page table read uses upper and lower pointers as address.
// - Current-page table read uses current page with lower pointer.
// - Last-page table read uses last page with lower pointer, no flags.
// - Xor from memory puts result in accumulator, updates zero flag only.
// - Xor to memory writes result back, updates zero flag only.
// - Immediate xor puts result in accumulator, updates zero flag only.
module sstx_exec #(
    parameter int unsigned PADDR_W = sstx_pkg::PADDR_W
) (
    // Clock and reset
    input  wire logic                        ref_clk_i,
    input  wire logic                        rst_b_i,
    // Decoded instruction
    input  wire logic                        op_valid_i,
    input  wire logic [sstx_pkg::OP_W-1:0]   op_code_i,
    input  wire logic [sstx_pkg::DATA_W-1:0] mem_rdata_i,
    input  wire logic [sstx_pkg::DATA_W-1:0] imm_i,
    input  wire logic [sstx_pkg::BIT_SEL_W-1:0] bit_sel_i,
    // Table pointers and program counter page
    input  wire logic [sstx_pkg::DATA_W-1:0] table_pointer_upper_i,
    input  wire logic [sstx_pkg::DATA_W-1:0] table_pointer_lower_i,
    input  wire logic [PADDR_W-1:0]          pc_i,
    // Program memory loading
    input  wire logic                        rom_wr_en_i,
    input  wire logic [PADDR_W-1:0]          rom_wr_addr_i,
    input  wire logic [sstx_pkg::PROG_W-1:0] rom_wr_data_i,
    // Data memory write back
    output logic                             mem_we_o,
    output logic      [sstx_pkg::DATA_W-1:0] mem_wdata_o,
    // Core state
    output logic      [sstx_pkg::DATA_W-1:0] acc_o,
    output logic                             zero_flag_o,
    output logic      [sstx_pkg::DATA_W-1:0] table_high_byte_latch_o,
    // Sequencing
    output logic                             skip_o,
    output logic                             dummy_cycle_o,
    output logic                             busy_o
);
    typedef enum logic [1:0] {SSTX_IDLE, SSTX_TABLE, SSTX_DUMMY} sstx_st_e;

    localparam int unsigned LOW_W = sstx_pkg::DATA_W;

    sstx_st_e                    st_q;
    sstx_st_e                    st_d;
    logic [sstx_pkg::DATA_W-1:0] acc_q;
    logic [sstx_pkg::DATA_W-1:0] acc_d;
    logic                        zf_q;
    logic                        zf_d;
    logic [sstx_pkg::DATA_W-1:0] table_high_byte_latch_q;
    logic [sstx_pkg::DATA_W-1:0] table_high_byte_latch_d;
    logic                        we_q;
    logic                        we_d;
    logic [sstx_pkg::DATA_W-1:0] wdata_q;
    logic [sstx_pkg::DATA_W-1:0] wdata_d;
    logic                        skip_q;
    logic                        skip_d;
    logic [sstx_pkg::PROG_W-1:0] rom_rdata;

    // Nibble exchange used by both swap forms
    function automatic logic [7:0] nib_swap(input logic [7:0] v);
        nib_swap = {v[sstx_pkg::NIB_LO_MSB:0],
                    v[sstx_pkg::DATA_W-1:sstx_pkg::NIB_HI_LSB]};
    endfunction : nib_swap

    // Zero test shared by skips and xor flag
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == 8'h00);
    endfunction : is_zero

    // Decode
    wire accept     = op_valid_i && (st_q == SSTX_IDLE);
    wire op_swapm   = accept && (op_code_i == sstx_pkg::SSTX_OP_SWAP_MEM);
    wire op_nibble_exchange_to_acc   = accept && (op_code_i == sstx_pkg::SSTX_OP_SWAP_ACC);
    wire op_sz      = accept && (op_code_i == sstx_pkg::SSTX_OP_SKIP_ZERO);
    wire op_sza     = accept && (op_code_i == sstx_pkg::SSTX_OP_COPY_SKIP);
    wire op_szb     = accept && (op_code_i == sstx_pkg::SSTX_OP_SKIP_BIT);
    wire op_tg      = accept && (op_code_i == sstx_pkg::SSTX_OP_TAB_GIVEN);
    wire op_tc      = accept && (op_code_i == sstx_pkg::SSTX_OP_TAB_CURR);
    wire op_tl      = accept && (op_code_i == sstx_pkg::SSTX_OP_TAB_LAST);
    wire op_xa      = accept && (op_code_i == sstx_pkg::SSTX_OP_XOR_ACC);
    wire op_xm      = accept && (op_code_i == sstx_pkg::SSTX_OP_XOR_MEM);
    wire op_xi      = accept && (op_code_i == sstx_pkg::SSTX_OP_XOR_IMM);
    wire op_tab     = op_tg || op_tc || op_tl;

    // Skip conditions
    wire bit_zero   = ~mem_rdata_i[bit_sel_i];
    wire skip_now   = (op_sz && is_zero(mem_rdata_i))
                   || (op_sza && is_zero(mem_rdata_i))
                   || (op_szb && bit_zero);

    // Xor results
    wire [7:0] xor_mem  = acc_q ^ mem_rdata_i;
    wire [7:0] xor_imm  = acc_q ^ imm_i;

    // Table address: given form truncates the full pair to program width; current and last forms use a page with the lower pointer
    wire [15:0]        pair_addr = {table_pointer_upper_i,
                                    table_pointer_lower_i};
    wire [PADDR_W-1:0] addr_given = pair_addr[PADDR_W-1:0];
    wire [PADDR_W-1:0] addr_curr  = {pc_i[PADDR_W-1:LOW_W],
                                     table_pointer_lower_i};
    wire [PADDR_W-1:0] addr_last  = {{(PADDR_W-LOW_W){1'b1}},
                                     table_pointer_lower_i};
    wire [PADDR_W-1:0] tab_addr   = op_tg ? addr_given
                                  : (op_tc ? addr_curr : addr_last);

    sstx_prog_rom #(
        .AW (PADDR_W),
        .DW (sstx_pkg::PROG_W)
    ) u_rom (
        .ref_clk_i (ref_clk_i),
        .wr_en_i   (rom_wr_en_i),
        .wr_addr_i (rom_wr_addr_i),
        .wr_data_i (rom_wr_data_i),
        .rd_en_i   (op_tab),
        .rd_addr_i (tab_addr),
        .rd_data_o (rom_rdata)
    );

    // Next state; flags untouched by all but the xor forms
    always_comb begin
        st_d    = st_q;
        acc_d   = acc_q;
        zf_d    = zf_q;
        table_high_byte_latch_d  = table_high_byte_latch_q;
        we_d    = 1'b0;
        wdata_d = wdata_q;
        skip_d  = 1'b0;
        case (st_q)
            SSTX_IDLE: begin
                if (op_swapm) begin
                    we_d    = 1'b1;
                    wdata_d = nib_swap(mem_rdata_i);
                end
                if (op_nibble_exchange_to_acc) begin
                    acc_d = nib_swap(mem_rdata_i);
                end
                if (op_sza) begin
                    acc_d = mem_rdata_i;
                end
                if (op_xa) begin
                    acc_d = xor_mem;
                    zf_d  = is_zero(xor_mem);
                end
                if (op_xm) begin
                    we_d    = 1'b1;
                    wdata_d = xor_mem;
                    zf_d    = is_zero(xor_mem);
                end
                if (op_xi) begin
                    acc_d = xor_imm;
                    zf_d  = is_zero(xor_imm);
                end
                if (op_tab) begin
                    st_d = SSTX_TABLE;
                end
                if (skip_now) begin
                    skip_d = 1'b1;
                    st_d   = SSTX_DUMMY;
                end
            end
            SSTX_TABLE: begin
                // Read data is registered, so write-back is a cycle later
                we_d    = 1'b1;
                wdata_d = rom_rdata[LOW_W-1:0];
                table_high_byte_latch_d  = rom_rdata[sstx_pkg::PROG_W-1:LOW_W];
                st_d    = SSTX_IDLE;
            end
            SSTX_DUMMY: begin
                st_d = SSTX_IDLE;
            end
            default: begin
                st_d = SSTX_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            st_q    <= SSTX_IDLE;
            acc_q   <= sstx_pkg::ACC_RST;
            zf_q    <= sstx_pkg::ZF_RST;
            table_high_byte_latch_q  <= sstx_pkg::TABLE_HIGH_BYTE_LATCH_RST;
            we_q    <= 1'b0;
            wdata_q <= 8'h00;
            skip_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            acc_q   <= acc_d;
            zf_q    <= zf_d;
            table_high_byte_latch_q  <= table_high_byte_latch_d;
            we_q    <= we_d;
            wdata_q <= wdata_d;
            skip_q  <= skip_d;
        end
    end

    // Outputs; an unmet skip simply leaves busy low
    assign mem_we_o                = we_q;
    assign mem_wdata_o             = wdata_q;
    assign acc_o                   = acc_q;
    assign zero_flag_o             = zf_q;
    assign table_high_byte_latch_o = table_high_byte_latch_q;
    assign skip_o                  = skip_q;
    assign dummy_cycle_o           = (st_q == SSTX_DUMMY);
    assign busy_o                  = (st_q != SSTX_IDLE);
endmodule : sstx_exec
`default_nettype wire

/* File: tb/sstx_dmem.sv */
// Data byte model on the far side of the unit
`timescale 1ns/1ps
`default_nettype none
module sstx_dmem (
    // Clock, bench preload and unit write data
    input  wire logic       ref_clk_i, ld_i,
    input  wire logic [7:0] ld_data_i, wdata_i,
    // Unit write strobe and read data
    input  wire logic       we_i,
    output logic      [7:0] rdata_o
);
    logic [7:0] mem_q;
    // Preload passes straight through so one cycle sets byte and op
    assign rdata_o = ld_i ? ld_data_i : mem_q;
    always_ff @(posedge ref_clk_i) if (we_i) mem_q <= wdata_i;
endmodule : sstx_dmem
`default_nettype wire

/* File: tb/sstx_exec_checker.sv */
// Port-level assertions for the swap, skip, table and xor unit
`timescale 1ns/1ps
`default_nettype none
module sstx_exec_checker (
    // Clock, reset and single-bit signals
    input wire logic       ref_clk_i, rst_b_i, op_valid_i, busy_o,
    input wire logic       mem_we_o, zero_flag_o, skip_o, dummy_cycle_o,
    // Operation and data
    input wire logic [3:0] op_code_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic [7:0] mem_rdata_i, imm_i, mem_wdata_o, acc_o
);
    // Accepted request one-hot by code; requests while busy are dropped
    wire logic        t   = op_valid_i && !busy_o;
    wire logic [15:0] h   = 16'(t) << op_code_i;
    wire logic [7:0]  sw  = {mem_rdata_i[3:0], mem_rdata_i[7:4]};
    wire logic        bz  = !mem_rdata_i[bit_sel_i];
    wire logic        tab = |h[8:6]; // Three table read codes
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    a_swap_mem_wr: assert property (h[sstx_pkg::SSTX_OP_SWAP_MEM] |=>
        mem_we_o && mem_wdata_o == $past(sw) && $stable({acc_o, zero_flag_o}))
        else $error("swap into memory wrong");
    a_swap_acc_ld: assert property (h[sstx_pkg::SSTX_OP_SWAP_ACC] |=>
        acc_o == $past(sw) && !mem_we_o && $stable(zero_flag_o))
        else $error("swap into acc wrong");
    a_skip_dummy: assert property (skip_o |-> dummy_cycle_o && busy_o
        ##1 !skip_o && !busy_o) else $error("skip not two cycles");
    a_byte_zero: assert property (h[sstx_pkg::SSTX_OP_SKIP_ZERO] |=>
        skip_o == ($past(mem_rdata_i) == 8'h00) && !mem_we_o)
        else $error("byte zero skip wrong");
    a_copy_skip: assert property (h[sstx_pkg::SSTX_OP_COPY_SKIP] |=>
        acc_o == $past(mem_rdata_i) && $stable(zero_flag_o)
        && skip_o == ($past(mem_rdata_i) == 8'h00))
        else $error("copy and skip wrong");
    a_xor_acc_ld: assert property (h[sstx_pkg::SSTX_OP_XOR_ACC] |=>
        acc_o == $past(acc_o ^ mem_rdata_i) && !mem_we_o
        && zero_flag_o == (acc_o == 8'h00)) else $error("xor acc wrong");
    a_bit_zero: assert property (h[sstx_pkg::SSTX_OP_SKIP_BIT] |=>
        skip_o == $past(bz) && !mem_we_o) else $error("bit skip wrong");
    a_table_seq: assert property (tab |=> busy_o && !mem_we_o
        ##1 mem_we_o && !busy_o && $stable(zero_flag_o))
        else $error("table read timing wrong");
    a_xor_mem_wr: assert property (h[sstx_pkg::SSTX_OP_XOR_MEM] |=>
        mem_we_o && mem_wdata_o == $past(acc_o ^ mem_rdata_i) && $stable(acc_o)
        && zero_flag_o == (mem_wdata_o == 8'h00)) else $error("xor mem wrong");
    a_xor_imm_acc: assert property (h[sstx_pkg::SSTX_OP_XOR_IMM] |=>
        acc_o == $past(acc_o ^ imm_i) && zero_flag_o == (acc_o == 8'h00))
        else $error("xor immediate wrong");
    // Main scenarios reached
    c_skip: cover property (skip_o);
    c_table: cover property (tab ##2 !busy_o);
    c_zero: cover property (h[sstx_pkg::SSTX_OP_XOR_IMM] ##1 zero_flag_o);
endmodule : sstx_exec_checker
bind sstx_exec sstx_exec_checker u_chk (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i), .op_valid_i(op_valid_i), .busy_o(busy_o),
    .mem_we_o(mem_we_o), .zero_flag_o(zero_flag_o), .skip_o(skip_o),
    .dummy_cycle_o(dummy_cycle_o), .op_code_i(op_code_i),
    .bit_sel_i(bit_sel_i), .mem_rdata_i(mem_rdata_i), .imm_i(imm_i),
    .mem_wdata_o(mem_wdata_o), .acc_o(acc_o));
`default_nettype wire

/* File: tb/tb.sv */
// Scenario bench for the swap, skip, table and xor unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb;
    logic        ref_clk_i = 1'b0, rst_b_i = 1'b0, vld = 1'b0, rom_we = 1'b0;
    logic [3:0]  code = 4'h0;
    logic [7:0]  m = 8'h00, x = 8'h00, rdata, wdata, acc, table_high_byte_latch;
    logic [11:0] rom_a = 12'h000;
    logic [15:0] rom_d = 16'h0000;
    logic        we, zf, skip, dummy, busy;
    int          errors = 0, n_compared = 0;
    // 25 MHz core clock
    always #20 ref_clk_i = ~ref_clk_i;
    // Pointers pick pages 2 (given), 5 (current) and 15 (last)
    sstx_exec dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .op_valid_i(vld), .op_code_i(code), .mem_rdata_i(rdata), .imm_i(x),
        .bit_sel_i(x[2:0]), .table_pointer_upper_i(8'h02),
        .table_pointer_lower_i(8'h34), .pc_i(12'h5ab), .rom_wr_en_i(rom_we),
        .rom_wr_addr_i(rom_a), .rom_wr_data_i(rom_d), .mem_we_o(we),
        .mem_wdata_o(wdata), .acc_o(acc), .zero_flag_o(zf),
        .table_high_byte_latch_o(table_high_byte_latch), .skip_o(skip),
        .dummy_cycle_o(dummy), .busy_o(busy));
    sstx_dmem u_mem (.ref_clk_i(ref_clk_i), .ld_i(vld), .ld_data_i(m),
        .wdata_i(wdata), .we_i(we), .rdata_o(rdata));
    // One instruction for one edge; results read once they have landed
    task automatic op(input logic [3:0] c, input logic [7:0] d, e);
        @(posedge ref_clk_i);
        rom_we <= 1'b0;
        vld <= 1'b1;
        code <= c;
        m <= d;
        x <= e;
        @(posedge ref_clk_i);
        vld <= 1'b0;
        #1;
    endtask : op
    task automatic t_xor;
        op(sstx_pkg::SSTX_OP_COPY_SKIP, 8'h5a, 8'h00);
        `CHK("copy acc", 8'h5a, acc)
        op(sstx_pkg::SSTX_OP_XOR_MEM, 8'h5a, 8'h00);
        `CHK("xor mem", 8'h00, wdata)
        `CHK("xor mem acc", 8'h5a, acc)
        `CHK("xor mem zf", 1'b1, zf)
        op(sstx_pkg::SSTX_OP_XOR_ACC, 8'h0f, 8'h00);
        `CHK("xor acc", 8'h55, acc)
        `CHK("xor acc zf", 1'b0, zf)
        op(sstx_pkg::SSTX_OP_XOR_IMM, 8'h00, 8'h55);
        `CHK("xor imm", 8'h00, acc)
        `CHK("xor imm zf", 1'b1, zf)
        $display("test xor done");
    endtask : t_xor
    task automatic t_swap;
        op(sstx_pkg::SSTX_OP_SWAP_ACC, 8'h3c, 8'h00);
        `CHK("swap acc", 8'hc3, acc)
        `CHK("swap acc we", 1'b0, we)
        op(sstx_pkg::SSTX_OP_SWAP_MEM, 8'ha5, 8'h00);
        `CHK("swap mem", 8'h5a, wdata)
        `CHK("swap mem acc", 8'hc3, acc)
        `CHK("swap zf", 1'b1, zf)
        $display("test swap done");
    endtask : t_swap
    task automatic t_skip;
        op(sstx_pkg::SSTX_OP_SKIP_ZERO, 8'h00, 8'h00);
        `CHK("skip met", 1'b1, skip)
        `CHK("dummy", 1'b1, dummy)
        @(posedge ref_clk_i);
        #1;
        `CHK("skip ends", 1'b0, busy)
        op(sstx_pkg::SSTX_OP_SKIP_ZERO, 8'h01, 8'h00);
        `CHK("skip unmet", 2'b00, {skip, busy})
        op(sstx_pkg::SSTX_OP_SKIP_BIT, 8'hf7, 8'h03);
        `CHK("bit skip met", 1'b1, skip)
        op(sstx_pkg::SSTX_OP_SKIP_BIT, 8'hf7, 8'h02);
        `CHK("bit skip unmet", 1'b0, skip)
        op(sstx_pkg::SSTX_OP_COPY_SKIP, 8'h00, 8'h00);
        `CHK("copy skip", 9'h100, {skip, acc})
        $display("test skip done");
    endtask : t_skip
    task automatic t_table;
        logic [3:0]  c[3];
        logic [11:0] a[3];
        logic [15:0] w[3];
        c = '{sstx_pkg::SSTX_OP_TAB_GIVEN, sstx_pkg::SSTX_OP_TAB_CURR,
              sstx_pkg::SSTX_OP_TAB_LAST};
        a = '{12'h234, 12'h534, 12'hf34};
        w = '{16'ha1b2, 16'hc3d4, 16'he5f6};
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk_i);
            rom_we <= 1'b1;
            rom_a <= a[i];
            rom_d <= w[i];
            op(c[i], 8'h00, 8'h00);
            `CHK("tab busy", 1'b1, busy)
            @(posedge ref_clk_i);
            #1;
            `CHK("tab low", {1'b1, w[i][7:0]}, {we, wdata})
            `CHK("tab high", w[i][15:8], table_high_byte_latch)
            `CHK("tab zf", 1'b1, zf)
        end
        $display("test table done");
    endtask : t_table
    task automatic finish_test;
        $display("compared %0d mismatched %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        t_xor;
        t_swap;
        t_skip;
        t_table;
        finish_test;
    end
    // Tests need some 40 cycles; over thirty times that means a hang
    initial begin
        repeat (1500) @(posedge ref_clk_i);
        errors++;
        finish_test;
    end
endmodule : tb
`default_nettype wire
